// ---- hdl/pfd_top.sv ----
// Feedback divider, reference range and calibration trigger registers of the second loop behind APB.
// Overview of operation
// - The range field in bits 4:2 decodes 0, 1, 2 and 4 as the four input bands, other codes are reserved.
// - Bit 0 of the reference register enables the reference doubler ahead of the phase detector.
// - Zero-delay feedback is forced off for the whole calibration, whatever its setting.
// - With the feedback source select at 1, calibration divides by the calibration divider.
// - When calibration ends, the loop returns to the normal feedback divider.
// - The calibration divider is 0x163[1:0], 0x164 and 0x165 as the low byte, and 0 is invalid.
// - The feedback divider is 0x166[1:0], 0x167 and 0x168 as the low byte, and 0 is invalid.
// - A write to 0x168 starts calibration when the disable bit is clear.
// - With the disable bit set, a write to 0x168 updates the divider without calibration.
// - The prescaler divides by its 3-bit code, except code 0 gives 8 and code 1 gives 2.
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pfd_map.svh"
module pfd_top
    import pfd_pkg::*;
#(
    parameter int CAL_CYCLES = `PFD_CAL_CYCLES
)(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Loop controls.
    output logic      [17:0] loop_divider,
    output logic      [3:0]  prescaler_ratio,
    output logic             ref_doubler_enable,
    output logic      [2:0]  ref_freq_range,
    output logic             ref_range_valid,
    output logic             zero_delay_active,
    output logic             cal_busy,
    output logic             divider_invalid
);
    // Calibration link.
    pfd_cal_if cal_link ();

    pfd_cal_seq #(
        .CAL_CYCLES (CAL_CYCLES)
    ) i_pfd_cal_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .cal     (cal_link.seq)
    );

    // Software registers.
    logic [7:0]  ref_cfg_q;
    logic [7:0]  ref_cfg_d;
    logic [1:0]  cal_high_q;
    logic [1:0]  cal_high_d;
    logic [7:0]  cal_mid_q;
    logic [7:0]  cal_mid_d;
    logic [7:0]  cal_low_q;
    logic [7:0]  cal_low_d;
    logic [1:0]  fb_high_q;
    logic [1:0]  fb_high_d;
    logic        cal_dis_q;
    logic        cal_dis_d;
    logic [7:0]  fb_mid_q;
    logic [7:0]  fb_mid_d;
    logic [7:0]  fb_low_q;
    logic [7:0]  fb_low_d;
    logic [17:0] fb_div_q;
    logic [17:0] fb_div_d;
    logic        src_sel_q;
    logic        src_sel_d;
    logic        zd_en_q;
    logic        zd_en_d;

    // Bus response registers.
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        slverr_q;
    logic        slverr_d;

    // Registered loop outputs.
    logic [17:0] loop_div_q;
    logic [17:0] loop_div_d;
    logic [3:0]  presc_q;
    logic [3:0]  presc_d;
    logic        zd_act_q;
    logic        zd_act_d;
    logic        range_ok_q;
    logic        range_ok_d;
    logic        div_bad_q;
    logic        div_bad_d;

    // Decode helpers.
    logic        setup;
    logic        wr_en;
    logic [9:0]  idx;
    logic        aligned;
    logic        mapped;
    logic        start;
    logic [17:0] cal_full;
    logic [2:0]  presc_code;
    logic [2:0]  range_code;

    assign setup      = psel & ~penable;
    assign idx        = paddr[11:2];
    assign aligned    = (paddr[1:0] == 2'h0);
    assign wr_en      = psel & penable & pwrite & ~slverr_q & pstrb[0];
    assign cal_full   = {cal_high_q, cal_mid_q, cal_low_q};
    assign presc_code = ref_cfg_q[`PFD_PRESC_MSB:`PFD_PRESC_LSB];
    assign range_code = ref_cfg_q[`PFD_RANGE_MSB:`PFD_RANGE_LSB];

    // Address decode; anything else is answered with an error.
    always_comb
    begin
        unique case (idx)
            `PFD_IDX_REF_CFG,
            `PFD_IDX_CAL_HIGH,
            `PFD_IDX_CAL_MID,
            `PFD_IDX_CAL_LOW,
            `PFD_IDX_FB_HIGH,
            `PFD_IDX_FB_MID,
            `PFD_IDX_FB_LOW,
            `PFD_IDX_CTRL,
            `PFD_IDX_STATUS: mapped = aligned;
            default:         mapped = 1'b0;
        endcase
    end

    // Read data and error are captured in the setup cycle so the access
    // phase answers from flip-flops with no wait state.
    always_comb
    begin
        prdata_d = prdata_q;
        slverr_d = slverr_q;
        if (setup)
        begin
            slverr_d = ~mapped;
            prdata_d = 32'h0000_0000;
            unique case (idx)
                `PFD_IDX_REF_CFG:  prdata_d[7:0] = {ref_cfg_q[7:2], 1'b0, ref_cfg_q[0]};
                `PFD_IDX_CAL_HIGH: prdata_d[1:0] = cal_high_q;
                `PFD_IDX_CAL_MID:  prdata_d[7:0] = cal_mid_q;
                `PFD_IDX_CAL_LOW:  prdata_d[7:0] = cal_low_q;
                `PFD_IDX_FB_HIGH:  prdata_d[2:0] = {cal_dis_q, fb_high_q};
                `PFD_IDX_FB_MID:   prdata_d[7:0] = fb_mid_q;
                `PFD_IDX_FB_LOW:   prdata_d[7:0] = fb_low_q;
                `PFD_IDX_CTRL:     prdata_d[1:0] = {zd_en_q, src_sel_q};
                `PFD_IDX_STATUS:   prdata_d[4:0] = {div_bad_q, range_ok_q, zd_act_q, cal_link.busy, src_sel_q};
                default:           prdata_d = 32'h0000_0000;
            endcase
            if (!aligned)
                prdata_d = 32'h0000_0000;
        end
    end

    // Register writes take effect at the access edge; reserved bits stay zero.
    always_comb
    begin
        ref_cfg_d  = ref_cfg_q;
        cal_high_d = cal_high_q;
        cal_mid_d  = cal_mid_q;
        cal_low_d  = cal_low_q;
        fb_high_d  = fb_high_q;
        cal_dis_d  = cal_dis_q;
        fb_mid_d   = fb_mid_q;
        fb_low_d   = fb_low_q;
        fb_div_d   = fb_div_q;
        src_sel_d  = src_sel_q;
        zd_en_d    = zd_en_q;
        start      = 1'b0;
        if (wr_en)
        begin
            unique case (idx)
                `PFD_IDX_REF_CFG:  ref_cfg_d  = {pwdata[7:2], 1'b0, pwdata[0]};
                `PFD_IDX_CAL_HIGH: cal_high_d = pwdata[1:0];
                `PFD_IDX_CAL_MID:  cal_mid_d  = pwdata[7:0];
                `PFD_IDX_CAL_LOW:  cal_low_d  = pwdata[7:0];
                `PFD_IDX_FB_HIGH:
                begin
                    fb_high_d = pwdata[1:0];
                    cal_dis_d = pwdata[`PFD_CAL_DIS_BIT];
                end
                `PFD_IDX_FB_MID:   fb_mid_d   = pwdata[7:0];
                `PFD_IDX_FB_LOW:
                begin
                    // Upper bytes wait in their registers until this write.
                    fb_low_d = pwdata[7:0];
                    fb_div_d = {fb_high_q, fb_mid_q, pwdata[7:0]};
                    start    = ~cal_dis_q;
                end
                `PFD_IDX_CTRL:
                begin
                    src_sel_d = pwdata[`PFD_CTRL_SRC_BIT];
                    zd_en_d   = pwdata[`PFD_CTRL_ZD_BIT];
                end
                default:
                begin
                end
            endcase
        end
    end

    assign cal_link.start = start;

    // Loop settings seen by the analog side.
    always_comb
    begin
        // The calibration divider only stands in while the routine runs.
        if (cal_link.busy && src_sel_q)
            loop_div_d = cal_full;
        else
            loop_div_d = fb_div_q;
        // The start strobe drops zero delay at the edge where busy rises, so the two never overlap.
        zd_act_d = zd_en_q & ~cal_link.busy & ~start;
        unique case (presc_code)
            `PFD_PRESC_CODE_DIV8: presc_d = `PFD_PRESC_RATIO8;
            `PFD_PRESC_CODE_DIV2: presc_d = `PFD_PRESC_RATIO2;
            default:              presc_d = {1'b0, presc_code};
        endcase
        unique case (range_code)
            PFD_RANGE_63,
            PFD_RANGE_127,
            PFD_RANGE_255,
            PFD_RANGE_500: range_ok_d = 1'b1;
            default:       range_ok_d = 1'b0;
        endcase
        // A zero divide value is flagged rather than passed on silently.
        div_bad_d = (fb_div_q == 18'h00000) | (cal_full == 18'h00000);
    end

    // All state registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ref_cfg_q  <= `PFD_RST_REF_CFG;
            cal_high_q <= `PFD_RST_DIV_HIGH;
            cal_mid_q  <= `PFD_RST_DIV_MID;
            cal_low_q  <= `PFD_RST_DIV_LOW;
            fb_high_q  <= `PFD_RST_DIV_HIGH;
            cal_dis_q  <= 1'b0;
            fb_mid_q   <= `PFD_RST_DIV_MID;
            fb_low_q   <= `PFD_RST_DIV_LOW;
            fb_div_q   <= `PFD_RST_DIV_FULL;
            src_sel_q  <= 1'b0;
            zd_en_q    <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            slverr_q   <= 1'b0;
            loop_div_q <= `PFD_RST_DIV_FULL;
            presc_q    <= `PFD_PRESC_RATIO2;
            zd_act_q   <= 1'b0;
            range_ok_q <= 1'b0;
            div_bad_q  <= 1'b0;
        end
        else
        begin
            ref_cfg_q  <= ref_cfg_d;
            cal_high_q <= cal_high_d;
            cal_mid_q  <= cal_mid_d;
            cal_low_q  <= cal_low_d;
            fb_high_q  <= fb_high_d;
            cal_dis_q  <= cal_dis_d;
            fb_mid_q   <= fb_mid_d;
            fb_low_q   <= fb_low_d;
            fb_div_q   <= fb_div_d;
            src_sel_q  <= src_sel_d;
            zd_en_q    <= zd_en_d;
            prdata_q   <= prdata_d;
            slverr_q   <= slverr_d;
            loop_div_q <= loop_div_d;
            presc_q    <= presc_d;
            zd_act_q   <= zd_act_d;
            range_ok_q <= range_ok_d;
            div_bad_q  <= div_bad_d;
        end
    end

    // Outputs; the range is only a hint to calibration, so a reserved
    // code is reported but still passed through unchanged.
    assign prdata             = prdata_q;
    assign pready             = 1'b1;
    assign pslverr            = slverr_q & psel & penable;
    assign loop_divider       = loop_div_q;
    assign prescaler_ratio    = presc_q;
    assign ref_doubler_enable = ref_cfg_q[`PFD_DOUBLER_BIT];
    assign ref_freq_range     = range_code;
    assign ref_range_valid    = range_ok_q;
    assign zero_delay_active  = zd_act_q;
    assign cal_busy           = cal_link.busy;
    assign divider_invalid    = div_bad_q;
endmodule
`default_nettype wire

// ---- hdl/pfd_map.svh ----
// Register indices, field positions, reset values and timing counts of the feedback divider block.
`ifndef PFD_MAP_SVH
`define PFD_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define PFD_IDX_REF_CFG     10'h162
`define PFD_IDX_CAL_HIGH    10'h163
`define PFD_IDX_CAL_MID     10'h164
`define PFD_IDX_CAL_LOW     10'h165
`define PFD_IDX_FB_HIGH     10'h166
`define PFD_IDX_FB_MID      10'h167
`define PFD_IDX_FB_LOW      10'h168
`define PFD_IDX_CTRL        10'h170
`define PFD_IDX_STATUS      10'h171

// Field positions.
`define PFD_PRESC_MSB       7
`define PFD_PRESC_LSB       5
`define PFD_RANGE_MSB       4
`define PFD_RANGE_LSB       2
`define PFD_DOUBLER_BIT     0
`define PFD_CAL_DIS_BIT     2
`define PFD_CTRL_SRC_BIT    0
`define PFD_CTRL_ZD_BIT     1

// Reset values.
`define PFD_RST_REF_CFG     8'h4c
`define PFD_RST_DIV_HIGH    2'h0
`define PFD_RST_DIV_MID     8'h00
`define PFD_RST_DIV_LOW     8'h0c
`define PFD_RST_DIV_FULL    18'h0000c

// Prescaler codes that do not divide by their own value.
`define PFD_PRESC_CODE_DIV8 3'h0
`define PFD_PRESC_CODE_DIV2 3'h1
`define PFD_PRESC_RATIO8    4'h8
`define PFD_PRESC_RATIO2    4'h2

// Length of the calibration routine in clock cycles.
`define PFD_CAL_CYCLES      16

`endif

// ---- hdl/pfd_pkg.sv ----
// Types shared by the feedback divider modules.
package pfd_pkg;

    // Calibration sequencer state.
    typedef enum logic [0:0] {
        PFD_IDLE = 1'b0,
        PFD_RUN  = 1'b1
    } pfd_state_t;

    // Reference input frequency range codes.
    typedef enum logic [2:0] {
        PFD_RANGE_63  = 3'h0,
        PFD_RANGE_127 = 3'h1,
        PFD_RANGE_255 = 3'h2,
        PFD_RANGE_500 = 3'h4
    } pfd_range_t;

endpackage

// ---- hdl/pfd_cal_if.sv ----
// Link between the register block and the calibration sequencer.
`timescale 1ns/10ps
`default_nettype none
interface pfd_cal_if;
    logic start;
    logic busy;
    logic done;

    // Register side launches and watches.
    modport ctrl (output start, input busy, input done);
    // Sequencer side runs the routine.
    modport seq (input start, output busy, output done);
endinterface
`default_nettype wire

// ---- hdl/pfd_cal_seq.sv ----
// Calibration sequencer that holds the loop in calibration for a fixed cycle count.
`timescale 1ns/10ps
`default_nettype none
`include "pfd_map.svh"
module pfd_cal_seq
    import pfd_pkg::*;
#(
    parameter int CAL_CYCLES = `PFD_CAL_CYCLES
)(
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Link to the register block.
    pfd_cal_if.seq    cal
);
    localparam int CW = $clog2(CAL_CYCLES + 1);

    pfd_state_t    state_q;
    pfd_state_t    state_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          done_q;
    logic          done_d;

    // A new start while running restarts the count, so the routine always
    // sees the latest divider settings for its full length.
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        unique case (state_q)
            PFD_IDLE:
            begin
                if (cal.start)
                begin
                    state_d = PFD_RUN;
                    cnt_d   = CW'(CAL_CYCLES - 1);
                end
            end
            PFD_RUN:
            begin
                if (cal.start)
                    cnt_d = CW'(CAL_CYCLES - 1);
                else if (cnt_q == '0)
                begin
                    state_d = PFD_IDLE;
                    done_d  = 1'b1;
                end
                else
                    cnt_d = cnt_q - CW'(1);
            end
        endcase
    end

    // State registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= PFD_IDLE;
            cnt_q   <= '0;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
        end
    end

    assign cal.busy = (state_q == PFD_RUN);
    assign cal.done = done_q;
endmodule
`default_nettype wire

// ---- verif/pfd_top_asserts.sv ----
// Checker of the feedback divider block, bound to its top module.
`timescale 1ns/10ps
`default_nettype none
`include "pfd_map.svh"
module pfd_top_asserts #(
    parameter int CAL_CYCLES = 16
)(
    // Clock and reset.
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    // Loop controls.
    input wire logic [17:0] loop_divider,
    input wire logic [3:0]  prescaler_ratio,
    input wire logic        ref_doubler_enable,
    input wire logic        ref_range_valid,
    input wire logic        zero_delay_active,
    input wire logic        cal_busy
);
    // Writes that take effect, and the places they hit.
    wire logic wr     = psel && penable && pwrite && pready && pstrb[0];
    wire logic wr_ref = wr && paddr == {`PFD_IDX_REF_CFG, 2'b00};
    wire logic wr_fbl = wr && paddr == {`PFD_IDX_FB_LOW, 2'b00};
    logic [10:0] sh_q;
    logic [7:0]  lw_q;

    // Shadow of the disable bit, the upper divider bytes and the last byte written.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sh_q <= 11'h000;
            lw_q <= 8'h00;
        end
        else if (wr)
        begin
            lw_q <= pwdata[7:0];
            if (paddr == {`PFD_IDX_FB_HIGH, 2'b00})
                sh_q[10:8] <= pwdata[2:0];
            if (paddr == {`PFD_IDX_FB_MID, 2'b00})
                sh_q[7:0] <= pwdata[7:0];
        end
    end

    // Prescaler ratio that a code must give.
    function automatic logic [3:0] ratio(input logic [2:0] c);
        return (c == 3'h0) ? 4'h8 : (c == 3'h1) ? 4'h2 : {1'b0, c};
    endfunction

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_cal_start;
        wr_fbl && !sh_q[10] |=> cal_busy;
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("calibration did not start");
    property p_cal_off;
        wr_fbl && sh_q[10] && !cal_busy |=> !cal_busy;
    endproperty
    a_cal_off: assert property (p_cal_off) else $error("calibration started while disabled");
    property p_zd_off;
        cal_busy |-> !zero_delay_active;
    endproperty
    a_zd_off: assert property (p_zd_off) else $error("zero delay active in calibration");
    property p_presc;
        wr_ref |-> ##2 prescaler_ratio == ratio(lw_q[7:5]);
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler ratio wrong");
    property p_range;
        wr_ref |-> ##2 ref_range_valid == (lw_q[4:2] inside {3'h0, 3'h1, 3'h2, 3'h4});
    endproperty
    a_range: assert property (p_range) else $error("range valid flag wrong");
    property p_doubler;
        wr_ref |=> ref_doubler_enable == lw_q[0];
    endproperty
    a_doubler: assert property (p_doubler) else $error("doubler enable wrong");
    property p_fb_apply;
        wr_fbl && sh_q[10] && !cal_busy |-> ##2 loop_divider == {sh_q[9:0], lw_q};
    endproperty
    a_fb_apply: assert property (p_fb_apply) else $error("feedback divider not applied");
    property p_atomic;
        !wr_fbl && !cal_busy ##1 !cal_busy |=> $stable(loop_divider);
    endproperty
    a_atomic: assert property (p_atomic) else $error("divider changed without low byte write");
endmodule
bind pfd_top pfd_top_asserts #(.CAL_CYCLES(CAL_CYCLES)) i_pfd_top_asserts (.*);
`default_nettype wire

// ---- verif/test_pfd_top.sv ----
// Self-checking bench of the feedback divider block.
`timescale 1ns/10ps
`default_nettype none
`include "pfd_map.svh"
module test_pfd_top;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [17:0] loop_divider;
    logic [3:0]  prescaler_ratio;
    logic        ref_doubler_enable;
    logic [2:0]  ref_freq_range;
    logic        ref_range_valid;
    logic        zero_delay_active;
    logic        cal_busy;
    logic        divider_invalid;
    logic [31:0] rdata;
    logic        rerr;
    int          err_total  = 0;
    int          num_checks = 0;
    int          cyc        = 0;

    // A short calibration keeps the run brief.
    pfd_top #(.CAL_CYCLES(4)) i_pfd_top (.*);

    always #20 pclk = ~pclk;

    // One APB transfer, held until pready is seen high.
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, d};
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Compare one value and count the outcome.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 4'hf);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00, 4'hf);
        chk($sformatf("register %h", idx), {24'h0, e}, rdata);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            print_verdict();
        end
    end

    initial
    begin
        int c;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Reset contents and outputs.
        rd(`PFD_IDX_REF_CFG, 8'h4c);
        rd(`PFD_IDX_CAL_HIGH, 8'h00);
        rd(`PFD_IDX_CAL_LOW, 8'h0c);
        rd(`PFD_IDX_FB_HIGH, 8'h00);
        rd(`PFD_IDX_FB_LOW, 8'h0c);
        chk("loop divider", 32'(loop_divider), 32'h0000c);
        chk("prescaler", 32'(prescaler_ratio), 32'h2);
        chk("divider invalid", 32'(divider_invalid), 32'h0);
        chk("ready", 32'(pready), 32'h1);
        apb(1'b0, 10'h001, 8'h00, 4'hf);
        chk("unmapped error", 32'(rerr), 32'h1);
        chk("unmapped data", rdata, 32'h0);
        // Every prescaler and range code, with the reserved bit written high.
        for (c = 0; c < 8; c++)
        begin
            wr(`PFD_IDX_REF_CFG, {c[2:0], c[2:0], 1'b1, c[0]});
            repeat (3) @(negedge pclk);
            chk("prescaler", 32'(prescaler_ratio), 32'((c == 0) ? 8 : (c == 1) ? 2 : c));
            chk("range", 32'(ref_freq_range), 32'(c));
            chk("range valid", 32'(ref_range_valid), 32'(c inside {0, 1, 2, 4}));
            chk("doubler", 32'(ref_doubler_enable), 32'(c % 2));
            rd(`PFD_IDX_REF_CFG, {c[2:0], c[2:0], 1'b0, c[0]});
        end
        // Divider update with calibration disabled; upper bytes wait for the low byte.
        wr(`PFD_IDX_CTRL, 8'h03);
        rd(`PFD_IDX_CTRL, 8'h03);
        wr(`PFD_IDX_FB_HIGH, 8'h05);
        wr(`PFD_IDX_FB_MID, 8'h23);
        apb(1'b1, `PFD_IDX_FB_MID, 8'hff, 4'h0);
        repeat (2) @(negedge pclk);
        chk("loop divider", 32'(loop_divider), 32'h0000c);
        wr(`PFD_IDX_FB_LOW, 8'h45);
        repeat (2) @(negedge pclk);
        chk("loop divider", 32'(loop_divider), 32'h12345);
        chk("cal busy", 32'(cal_busy), 32'h0);
        rd(`PFD_IDX_FB_MID, 8'h23);
        // Calibration in cascaded mode, then back to the normal divider.
        // Software sets a real input band before it lets calibration run.
        wr(`PFD_IDX_REF_CFG, 8'h48);
        wr(`PFD_IDX_CAL_HIGH, 8'h02);
        rd(`PFD_IDX_CAL_HIGH, 8'h02);
        wr(`PFD_IDX_CAL_MID, 8'hab);
        wr(`PFD_IDX_CAL_LOW, 8'hcd);
        wr(`PFD_IDX_FB_HIGH, 8'h01);
        wr(`PFD_IDX_FB_LOW, 8'h45);
        repeat (3) @(negedge pclk);
        chk("cal busy", 32'(cal_busy), 32'h1);
        chk("loop divider", 32'(loop_divider), 32'h2abcd);
        chk("zero delay", 32'(zero_delay_active), 32'h0);
        for (c = 0; c < 20 && cal_busy !== 1'b0; c++)
            @(negedge pclk);
        repeat (2) @(negedge pclk);
        chk("cal busy", 32'(cal_busy), 32'h0);
        chk("loop divider", 32'(loop_divider), 32'h12345);
        chk("zero delay", 32'(zero_delay_active), 32'h1);
        rd(`PFD_IDX_STATUS, 8'h0d);
        // A zero calibration divider is flagged.
        wr(`PFD_IDX_CAL_HIGH, 8'h00);
        wr(`PFD_IDX_CAL_MID, 8'h00);
        wr(`PFD_IDX_CAL_LOW, 8'h00);
        repeat (2) @(negedge pclk);
        chk("divider invalid", 32'(divider_invalid), 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
